//--- hw/clk_status_pkg.sv
package clk_status_pkg;

    // management command codes of the readable words
    localparam logic [7:0] CMD_SYSTEM_STATUS   = 8'hDC;
    localparam logic [7:0] CMD_PART_IDENTIFIER = 8'hAD;
    localparam logic [7:0] CMD_SILICON_REV     = 8'hAE;
    localparam logic [7:0] CMD_CLOCK_HEALTH    = 8'hDF;

    // field positions of the clock health status byte
    localparam int CLK_SRC_BIT      = 0;
    localparam int PLL_LOCK_BIT     = 1;
    localparam int SS_DONE_BIT      = 2;
    localparam int SOFT_ON_BIT      = 3;
    localparam int SRC_CHANGED_BIT  = 4;
    localparam int LOOP_SHORT_BIT   = 5;
    localparam int FREQ_HEALTH_LSB  = 6;

    // field positions of the system status byte
    localparam int SW_MODE_BIT      = 3;
    localparam int PROT_MODE_BIT    = 4;
    localparam int OUT_MODE_BIT     = 5;

    // frequency pin health codes
    localparam logic [1:0] FREQ_OK         = 2'h0;
    localparam logic [1:0] FREQ_SHORT_LOW  = 2'h1;
    localparam logic [1:0] FREQ_OPEN_HIGH  = 2'h2;

    // mode strap comparator levels
    localparam logic [1:0] STRAP_GND       = 2'h0;
    localparam logic [1:0] STRAP_1V0       = 2'h1;
    localparam logic [1:0] STRAP_2V05      = 2'h2;
    localparam logic [1:0] STRAP_SUPPLY    = 2'h3;

    // values after reset
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [15:0] RD_DATA_RESET  = 16'h0000;

    // arbitrary neutral identification values
    localparam logic [15:0] PART_ID_DEFAULT  = 16'h5A01;
    localparam logic [15:0] SILICON_REV_DEFAULT = 16'h0101;

    // strap settling window after reset release
    localparam int CLK_PERIOD_PS      = 4000;
    localparam int STRAP_SETTLE_NS    = 2000;
    localparam int STRAP_SETTLE_CYC   = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                        / CLK_PERIOD_PS;
    localparam int STRAP_CNT_W        = 10;

    // switching sequencer states
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_RUN,
        SW_WAIT_ZERO,
        SW_RESTART
    } sw_state_t;

endpackage

//--- hw/sync_bits.sv
`timescale 1ns/1ps
`default_nettype none

module sync_bits #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    // stage1 feeds stage2 only, never logic
    always_comb
    begin
        next_cur        = cur;
        next_cur.stage1 = i_async;
        next_cur.stage2 = cur.stage1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign o_sync = cur.stage2;

endmodule

`default_nettype wire

//--- hw/phase_drive_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module phase_drive_encoder #(
    parameter int PHASES = 4
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // control
    input  wire logic              i_enable,
    input  wire logic              i_tri_state,
    input  wire logic [PHASES-1:0] i_high_side_on,
    // per phase level and mid-level request
    output logic      [PHASES-1:0] o_level,
    output logic      [PHASES-1:0] o_mid
);

    typedef struct packed {
        logic [PHASES-1:0] level;
        logic [PHASES-1:0] mid;
    } enc_state_t;

    enc_state_t cur;
    enc_state_t next_cur;

    // both switches off shows as mid level only in three-state mode
    always_comb
    begin
        next_cur = cur;
        for (int p = 0; p < PHASES; p++)
        begin
            next_cur.level[p] = i_enable & i_high_side_on[p];
            next_cur.mid[p]   = ~i_enable & i_tri_state;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign o_level = cur.level;
    assign o_mid   = cur.mid;

endmodule

`default_nettype wire

//--- hw/clock_status_and_mode_straps.sv
//
// Overview of operation
// - Status bit 0 shows clock source: zero internal oscillator, one external clock.
// - Status bit 1 set only when locked; unlocked withholds clock output and switching.
// - Status bit 2 set after main soft-start finishes, zero before.
// - Status bit 3 zero during soft-on transition, one in normal operation.
// - Status bit 4 set when clock source changes either way.
// - Status bit 5 set when loop filter pin is shorted to ground.
// - Status bits 7:6: 00 ok, 01 shorted low, 10 open or high.
// - Fixed read-only two-byte silicon revision word at command 0xAE.
// - Direction pin high selects boost, low selects buck.
// - Direction change while switching: stop phases, await zero cross, soft-start anew.
// - Three-state mode: high drives high side, low drives low side, mid both off.
// - Mode strap sampled only at startup, latched and kept afterwards.
// - Strap levels: ground diode hiccup, 1.0V pwm hiccup, 2.05V diode latch, supply pwm latch.
// - Latched switching mode and fault response readable in the system status byte.
//
`timescale 1ns/1ps
`default_nettype none

module clock_status_and_mode_straps #(
    parameter int          PHASES        = 4,
    parameter logic [15:0] PART_ID       = clk_status_pkg::PART_ID_DEFAULT,     // arbitrary
    parameter logic [15:0] SILICON_REV   = clk_status_pkg::SILICON_REV_DEFAULT  // arbitrary
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // management read port
    input  wire logic              i_rd_req,
    input  wire logic [7:0]        i_rd_cmd,
    output logic                   o_rd_valid,
    output logic                   o_rd_hit,
    output logic      [15:0]       o_rd_data,
    // clock and loop monitors from the analog side
    input  wire logic              i_ext_clock_used,
    input  wire logic              i_pll_locked,
    input  wire logic              i_soft_start_done,
    input  wire logic              i_soft_on_done,
    input  wire logic              i_loop_filter_short,
    input  wire logic              i_freq_set_pin_low,
    input  wire logic              i_freq_set_pin_high,
    // control pins from the microcontroller and straps
    input  wire logic              i_direction_select_pin,
    input  wire logic              i_switch_enable_pin,
    input  wire logic              i_tri_state_select_pin,
    input  wire logic [1:0]        i_mode_strap_level,
    input  wire logic              i_zero_cross,
    // modulator demand, same clock
    input  wire logic [PHASES-1:0] i_phase_demand,
    // clock output and phase drive
    output logic                   o_clock_output_pin_en,
    output logic      [PHASES-1:0] o_phase_drive_outputs,
    output logic      [PHASES-1:0] o_phase_drive_mid,
    // converter mode
    output logic                   o_boost_mode,
    output logic                   o_switching_active,
    output logic                   o_soft_start_req,
    output logic                   o_diode_emulation,
    output logic                   o_hiccup_mode,
    output logic                   o_strap_latched
);

    localparam int NSYNC = 13;

    // synchronised pin levels
    logic [NSYNC-1:0] pins_s;
    logic             ext_clk_s;
    logic             locked_s;
    logic             ss_done_s;
    logic             soft_on_s;
    logic             loop_short_s;
    logic             freq_low_s;
    logic             freq_high_s;
    logic             dir_s;
    logic             enable_s;
    logic             tri_s;
    logic [1:0]       strap_s;
    logic             zero_s;

    sync_bits #(
        .WIDTH   (NSYNC)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_ext_clock_used, i_pll_locked, i_soft_start_done, i_soft_on_done,
                   i_loop_filter_short, i_freq_set_pin_low, i_freq_set_pin_high,
                   i_direction_select_pin, i_switch_enable_pin, i_tri_state_select_pin,
                   i_mode_strap_level, i_zero_cross}),
        .o_sync  (pins_s)
    );

    assign ext_clk_s    = pins_s[12];
    assign locked_s     = pins_s[11];
    assign ss_done_s    = pins_s[10];
    assign soft_on_s    = pins_s[9];
    assign loop_short_s = pins_s[8];
    assign freq_low_s   = pins_s[7];
    assign freq_high_s  = pins_s[6];
    assign dir_s        = pins_s[5];
    assign enable_s     = pins_s[4];
    assign tri_s        = pins_s[3];
    assign strap_s      = pins_s[2:1];
    assign zero_s       = pins_s[0];

    typedef struct packed {
        clk_status_pkg::sw_state_t      sw;
        logic                           boost;
        logic                           restart_pend;
        logic                           ss_req;
        logic                           src_prev;
        logic                           src_prev_ok;
        logic                           src_changed;
        logic                           strap_done;
        logic [clk_status_pkg::STRAP_CNT_W-1:0] strap_cnt;
        logic                           diode_emul;
        logic                           hiccup;
        logic                           tri_mode;
        logic                           clk_out_en;
        logic [7:0]                     health;
        logic                           rd_valid;
        logic                           rd_hit;
        logic [15:0]                    rd_data;
    } top_state_t;

    top_state_t cur;
    top_state_t next_cur;

    // frequency pin health code; the open-high fault wins if both monitors fire
    function automatic logic [1:0] freq_code(input logic low_f, input logic high_f);
        freq_code = high_f ? clk_status_pkg::FREQ_OPEN_HIGH
                  : (low_f ? clk_status_pkg::FREQ_SHORT_LOW : clk_status_pkg::FREQ_OK);
    endfunction

    // strap decode: odd levels force pwm, upper levels latch off
    function automatic logic strap_is_diode(input logic [1:0] lvl);
        strap_is_diode = (lvl == clk_status_pkg::STRAP_GND)
                       | (lvl == clk_status_pkg::STRAP_2V05);
    endfunction

    function automatic logic strap_is_hiccup(input logic [1:0] lvl);
        strap_is_hiccup = (lvl == clk_status_pkg::STRAP_GND)
                        | (lvl == clk_status_pkg::STRAP_1V0);
    endfunction

    logic [7:0] sys_status;
    logic       may_switch;

    always_comb
    begin
        sys_status = clk_status_pkg::STATUS_RESET;
        sys_status[clk_status_pkg::SW_MODE_BIT]   = ~cur.diode_emul;
        sys_status[clk_status_pkg::PROT_MODE_BIT] = cur.hiccup;
        sys_status[clk_status_pkg::OUT_MODE_BIT]  = cur.tri_mode;
    end

    // no switching before lock and strap capture
    assign may_switch = enable_s & locked_s & cur.strap_done;

    always_comb
    begin
        next_cur        = cur;
        next_cur.ss_req = 1'b0;

        // strap sampled once after the settling window, then frozen
        if (!cur.strap_done)
        begin
            if (cur.strap_cnt == clk_status_pkg::STRAP_CNT_W'(clk_status_pkg::STRAP_SETTLE_CYC))
            begin
                next_cur.strap_done = 1'b1;
                next_cur.diode_emul = strap_is_diode(strap_s);
                next_cur.hiccup     = strap_is_hiccup(strap_s);
                next_cur.tri_mode   = tri_s;
            end
            else
            begin
                next_cur.strap_cnt = cur.strap_cnt + 1'b1;
            end
        end

        // source change flag, sticky until reset; armed late so sync flush is no change
        next_cur.src_prev    = ext_clk_s;
        next_cur.src_prev_ok = cur.strap_done;
        if (cur.src_prev_ok && (ext_clk_s != cur.src_prev))
        begin
            next_cur.src_changed = 1'b1;
        end

        // clock output only while locked
        next_cur.clk_out_en = locked_s;

        // switching sequencer
        case (cur.sw)
            clk_status_pkg::SW_IDLE:
            begin
                next_cur.boost = dir_s;
                if (may_switch)
                begin
                    next_cur.sw = clk_status_pkg::SW_RUN;
                end
            end
            clk_status_pkg::SW_RUN:
            begin
                if (!may_switch)
                begin
                    next_cur.sw           = clk_status_pkg::SW_IDLE;
                    next_cur.restart_pend = 1'b0;
                end
                else if (dir_s != cur.boost)
                begin
                    // tolerated reversal on the fly
                    next_cur.sw = clk_status_pkg::SW_WAIT_ZERO;
                end
                else if (ss_done_s)
                begin
                    next_cur.restart_pend = 1'b0;
                end
            end
            clk_status_pkg::SW_WAIT_ZERO:
            begin
                if (!may_switch)
                begin
                    next_cur.sw = clk_status_pkg::SW_IDLE;
                end
                else if (zero_s)
                begin
                    next_cur.sw = clk_status_pkg::SW_RESTART;
                end
            end
            clk_status_pkg::SW_RESTART:
            begin
                next_cur.boost        = dir_s;
                next_cur.ss_req       = 1'b1;
                next_cur.restart_pend = 1'b1;
                next_cur.sw           = may_switch ? clk_status_pkg::SW_RUN
                                                   : clk_status_pkg::SW_IDLE;
            end
            default:
            begin
                next_cur.sw = clk_status_pkg::SW_IDLE;
            end
        endcase

        // clock health byte, refreshed every cycle
        next_cur.health = clk_status_pkg::STATUS_RESET;
        next_cur.health[clk_status_pkg::CLK_SRC_BIT]     = ext_clk_s;
        next_cur.health[clk_status_pkg::PLL_LOCK_BIT]    = locked_s;
        next_cur.health[clk_status_pkg::SS_DONE_BIT]     = ss_done_s
                                                         & ~next_cur.restart_pend;
        next_cur.health[clk_status_pkg::SOFT_ON_BIT]     = soft_on_s
                                                         & ~next_cur.restart_pend;
        next_cur.health[clk_status_pkg::SRC_CHANGED_BIT] = next_cur.src_changed;
        next_cur.health[clk_status_pkg::LOOP_SHORT_BIT]  = loop_short_s;
        next_cur.health[clk_status_pkg::FREQ_HEALTH_LSB +: 2] =
            freq_code(freq_low_s, freq_high_s);

        // read answer one cycle after the request
        next_cur.rd_valid = i_rd_req;
        next_cur.rd_hit   = 1'b0;
        next_cur.rd_data  = clk_status_pkg::RD_DATA_RESET;
        if (i_rd_req)
        begin
            case (i_rd_cmd)
                clk_status_pkg::CMD_PART_IDENTIFIER:
                begin
                    next_cur.rd_hit  = 1'b1;
                    next_cur.rd_data = PART_ID;
                end
                clk_status_pkg::CMD_SILICON_REV:
                begin
                    next_cur.rd_hit  = 1'b1;
                    next_cur.rd_data = SILICON_REV;
                end
                clk_status_pkg::CMD_CLOCK_HEALTH:
                begin
                    next_cur.rd_hit  = 1'b1;
                    next_cur.rd_data = {8'h00, cur.health};
                end
                clk_status_pkg::CMD_SYSTEM_STATUS:
                begin
                    next_cur.rd_hit  = 1'b1;
                    next_cur.rd_data = {8'h00, sys_status};
                end
                default:
                begin
                    next_cur.rd_hit  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cur    <= '0;
            cur.sw <= clk_status_pkg::SW_IDLE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // phases stopped outside the run state
    phase_drive_encoder #(
        .PHASES         (PHASES)
    ) u_enc (
        .i_clk          (i_clk),
        .i_rst_n        (i_rst_n),
        .i_enable       (cur.sw == clk_status_pkg::SW_RUN),
        .i_tri_state    (cur.tri_mode),
        .i_high_side_on (i_phase_demand),
        .o_level        (o_phase_drive_outputs),
        .o_mid          (o_phase_drive_mid)
    );

    // register outputs
    assign o_rd_valid            = cur.rd_valid;
    assign o_rd_hit              = cur.rd_hit;
    assign o_rd_data             = cur.rd_data;
    assign o_clock_output_pin_en = cur.clk_out_en;
    assign o_boost_mode          = cur.boost;
    assign o_switching_active    = (cur.sw == clk_status_pkg::SW_RUN);
    assign o_soft_start_req      = cur.ss_req;
    assign o_diode_emulation     = cur.diode_emul;
    assign o_hiccup_mode         = cur.hiccup;
    assign o_strap_latched       = cur.strap_done;

endmodule

`default_nettype wire

//--- sim/clock_status_and_mode_straps_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module clock_status_and_mode_straps_asserts #(
    parameter int          PHASES      = 4,
    parameter logic [15:0] PART_ID     = 16'h0000,
    parameter logic [15:0] SILICON_REV = 16'h0000
) (
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    // read port
    input wire logic              i_rd_req,
    input wire logic [7:0]        i_rd_cmd,
    input wire logic              o_rd_valid,
    input wire logic              o_rd_hit,
    input wire logic [15:0]       o_rd_data,
    // converter side
    input wire logic              i_pll_locked,
    input wire logic              o_clock_output_pin_en,
    input wire logic [PHASES-1:0] o_phase_drive_outputs,
    input wire logic [PHASES-1:0] o_phase_drive_mid,
    input wire logic              o_switching_active,
    input wire logic              o_diode_emulation,
    input wire logic              o_hiccup_mode,
    input wire logic              o_strap_latched
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // read answers one cycle after the request
    property p_rd_answer;
        i_rd_req |=> o_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_stands;
        !i_rd_req |=> !o_rd_valid && !o_rd_hit && o_rd_data == 16'h0000;
    endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("read answer lingers");
    property p_part_id;
        i_rd_req && i_rd_cmd == clk_status_pkg::CMD_PART_IDENTIFIER
            |=> o_rd_hit && o_rd_data == PART_ID;
    endproperty
    a_part_id: assert property (p_part_id) else $error("part word wrong");
    property p_rev;
        i_rd_req && i_rd_cmd == clk_status_pkg::CMD_SILICON_REV
            |=> o_rd_hit && o_rd_data == SILICON_REV;
    endproperty
    a_rev: assert property (p_rev) else $error("revision word wrong");
    // lock gates the clock output and any switching
    property p_lock_clk;
        !i_pll_locked [*4] |-> !o_clock_output_pin_en;
    endproperty
    a_lock_clk: assert property (p_lock_clk) else $error("clock out while unlocked");
    property p_run_locked;
        o_switching_active |-> o_clock_output_pin_en && o_strap_latched;
    endproperty
    a_run_locked: assert property (p_run_locked) else $error("switching too early");
    // latched strap selections never move
    property p_strap_hold;
        o_strap_latched |=> o_strap_latched && $stable(o_diode_emulation)
            && $stable(o_hiccup_mode);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap result moved");
    property p_phase_off;
        !o_switching_active |=> o_phase_drive_outputs == '0;
    endproperty
    a_phase_off: assert property (p_phase_off) else $error("phases drive while stopped");
    property p_mid_off;
        o_phase_drive_mid != '0 |-> o_strap_latched && o_phase_drive_outputs == '0;
    endproperty
    a_mid_off: assert property (p_mid_off) else $error("mid level with drive");

    // main scenarios reached
    c_run: cover property ($rose(o_switching_active));
    c_mid: cover property (o_phase_drive_mid != '0);
    c_unmapped: cover property (o_rd_valid && !o_rd_hit);
endmodule

bind clock_status_and_mode_straps clock_status_and_mode_straps_asserts #(
    .PHASES(PHASES), .PART_ID(PART_ID), .SILICON_REV(SILICON_REV)
) i_chk (.i_clk, .i_rst_n, .i_rd_req, .i_rd_cmd, .o_rd_valid, .o_rd_hit, .o_rd_data,
    .i_pll_locked, .o_clock_output_pin_en, .o_phase_drive_outputs, .o_phase_drive_mid,
    .o_switching_active, .o_diode_emulation, .o_hiccup_mode, .o_strap_latched);

`default_nettype wire

//--- sim/mcu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module mcu_pin_model (
    // clock and wishes of the bench
    input  wire logic i_clk,
    input  wire logic i_want_dir,
    input  wire logic i_want_en,
    input  wire logic i_polite,
    // pins toward the device
    output var logic  o_dir,
    output var logic  o_en
);
    initial
    begin
        o_dir = 1'b0;
        o_en = 1'b0;
    end

    // polite mode drops enable first; impolite flips on the fly
    always @(negedge i_clk)
    begin
        if (o_dir != i_want_dir)
        begin
            if (i_polite && o_en)
                o_en <= 1'b0;
            else
                o_dir <= i_want_dir;
        end
        else
            o_en <= i_want_en;
    end
endmodule

`default_nettype wire

//--- sim/clock_status_and_mode_straps_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module clock_status_and_mode_straps_tb_top;
    localparam int PH = 4;
    logic          i_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    logic          i_rd_req = 1'b0;
    logic [7:0]    i_rd_cmd = 8'h00;
    logic          o_rd_valid, o_rd_hit;
    logic [15:0]   o_rd_data;
    logic [6:0]    mon = 7'h00;
    logic          want_dir = 1'b0, want_en = 1'b0, polite = 1'b1;
    logic          dir_pin, en_pin, chg;
    logic          tri_sel = 1'b0, zc = 1'b0;
    logic [1:0]    strap = 2'h0;
    logic [PH-1:0] demand = '0, drv, mid;
    logic          clk_en, boost, active, ss_req, diode, hic, latched;
    int            error_cnt = 0, num_checks = 0;

    always #2 i_clk = ~i_clk;

    // monitors packed as ext, lock, ss, soft-on, loop short, freq low, freq high
    clock_status_and_mode_straps #(.PHASES(PH)) i_clock_status_and_mode_straps (
        .i_clk, .i_rst_n, .i_rd_req, .i_rd_cmd, .o_rd_valid, .o_rd_hit, .o_rd_data,
        .i_ext_clock_used(mon[0]), .i_pll_locked(mon[1]), .i_soft_start_done(mon[2]),
        .i_soft_on_done(mon[3]), .i_loop_filter_short(mon[4]), .i_freq_set_pin_low(mon[5]),
        .i_freq_set_pin_high(mon[6]), .i_direction_select_pin(dir_pin),
        .i_switch_enable_pin(en_pin), .i_tri_state_select_pin(tri_sel),
        .i_mode_strap_level(strap), .i_zero_cross(zc), .i_phase_demand(demand),
        .o_clock_output_pin_en(clk_en), .o_phase_drive_outputs(drv), .o_phase_drive_mid(mid),
        .o_boost_mode(boost), .o_switching_active(active), .o_soft_start_req(ss_req),
        .o_diode_emulation(diode), .o_hiccup_mode(hic), .o_strap_latched(latched));

    mcu_pin_model i_mcu_pin_model (.i_clk, .i_want_dir(want_dir), .i_want_en(want_en),
        .i_polite(polite), .o_dir(dir_pin), .o_en(en_pin));

    // expected {diode emulation, hiccup} per strap level
    function automatic logic [1:0] strap_exp(input logic [1:0] lv);
        return {~lv[0], ~lv[1]};
    endfunction

    // high fault wins when both frequency pin faults show
    function automatic logic [7:0] health_exp(input logic [6:0] m, input logic c);
        return {m[6], m[5] & ~m[6], m[4], c, m[3], m[2], m[1], m[0]};
    endfunction

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one read, request held for exactly one taking edge
    task rdc(input logic [7:0] cmd, input logic hit, input logic [15:0] exp);
        @(negedge i_clk);
        i_rd_req = 1'b1;
        i_rd_cmd = cmd;
        @(negedge i_clk);
        i_rd_req = 1'b0;
        chk("rd_valid", {15'h0000, o_rd_valid}, 16'h0001);
        chk("rd_hit", {15'h0000, o_rd_hit}, {15'h0000, hit});
        chk("rd_data", o_rd_data, exp);
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        void'($urandom(20471));
        // each strap level needs its own startup, since it latches once
        for (int lv = 0; lv < 4; lv++)
        begin
            i_rst_n = 1'b0;
            strap = lv[1:0];
            tri_sel = lv[0];
            repeat (10) @(negedge i_clk);
            i_rst_n = 1'b1;
            for (int k = 0; k < 700 && latched !== 1'b1; k++) @(negedge i_clk);
            chk("strap", {13'h0000, latched, diode, hic},
                {13'h0000, 1'b1, strap_exp(lv[1:0])});
            rdc(clk_status_pkg::CMD_SYSTEM_STATUS, 1'b1,
                {10'h000, lv[0], ~lv[1], lv[0], 3'h0});
            strap = ~strap;
            repeat (8) @(negedge i_clk);
            chk("strap_kept", {14'h0000, diode, hic}, {14'h0000, strap_exp(lv[1:0])});
        end
        rdc(clk_status_pkg::CMD_PART_IDENTIFIER, 1'b1, clk_status_pkg::PART_ID_DEFAULT);
        rdc(clk_status_pkg::CMD_SILICON_REV, 1'b1, clk_status_pkg::SILICON_REV_DEFAULT);
        rdc(8'h00, 1'b0, 16'h0000);
        // random monitors with switching off; early rounds keep the source still
        chg = 1'b0;
        for (int n = 0; n < 24; n++)
        begin
            mon = 7'($urandom);
            if (n < 3)
                mon[0] = 1'b0;
            chg = chg | mon[0];
            repeat (4) @(negedge i_clk);
            chk("clk_out", {15'h0000, clk_en}, {15'h0000, mon[1]});
            rdc(clk_status_pkg::CMD_CLOCK_HEALTH, 1'b1,
                {8'h00, health_exp(mon, chg)});
        end
        // start in boost, then reverse with switching still on
        mon = 7'h0E;
        demand = PH'($urandom);
        want_dir = 1'b1;
        want_en = 1'b1;
        for (int k = 0; k < 40 && active !== 1'b1; k++) @(negedge i_clk);
        repeat (2) @(negedge i_clk);
        chk("boost", {15'h0000, boost}, 16'h0001);
        chk("drive", {4'h0, drv, 4'h0, mid}, {4'h0, demand, 8'h00});
        polite = 1'b0;
        want_dir = 1'b0;
        repeat (8) @(negedge i_clk);
        chk("stopped", {11'h000, active, drv}, 16'h0000);
        chk("mid_off", {12'h000, mid}, 16'h000F);
        zc = 1'b1;
        for (int k = 0; k < 20 && active !== 1'b1; k++) @(negedge i_clk);
        chk("buck", {13'h0000, ss_req, boost, active}, 16'h0005);
        zc = 1'b0;
        // polite reversal goes through idle, no zero cross needed
        polite = 1'b1;
        want_dir = 1'b1;
        for (int k = 0; k < 40 && {boost, active} !== 2'h3; k++) @(negedge i_clk);
        chk("boost_again", {14'h0000, boost, active}, 16'h0003);
        mon[1] = 1'b0;
        repeat (6) @(negedge i_clk);
        chk("unlocked", {13'h0000, clk_en, active, |drv}, 16'h0000);
        results();
    end

    // the run needs about 2300 cycles; allow plenty more before calling it hung
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
endmodule

`default_nettype wire
